// >>> hdl/ccr_chan_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_chan_mem
  import ccr_pkg::*;
#(
  parameter int DEPTH = ccr_pkg::CHAN_N,
  parameter int WIDTH = ccr_pkg::REG_W
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  // write port
  input  wire logic                          wrEn,
  input  wire logic [ccr_pkg::CHAN_W-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0]              wrData,
  input  wire logic [WIDTH-1:0]              wrMask,
  // bus read port
  input  wire logic [ccr_pkg::CHAN_W-1:0]    rdAddrA,
  output logic      [WIDTH-1:0]              rdDataA,
  // sequencer read port
  input  wire logic [ccr_pkg::CHAN_W-1:0]    rdAddrB,
  output logic      [WIDTH-1:0]              rdDataB,
  // per channel enable and setup fields
  output logic      [DEPTH-1:0]              enables,
  output logic      [DEPTH*SETUP_W-1:0]      setups
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem[0] <= CHAN0_RESET;
      for (int k = 1; k < DEPTH; k++) begin
        mem[k] <= CHANX_RESET;
      end
    end else if (ce && wrEn) begin
      mem[wrAddr] <= ((mem[wrAddr] & ~wrMask) | (wrData & wrMask)) & ~RSVD_MASK;
    end
  end

  // ---------------------------------------------------------------
  // registered reads
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdDataA <= '0;
      rdDataB <= '0;
    end else if (ce) begin
      rdDataA <= mem[rdAddrA];
      rdDataB <= mem[rdAddrB];
    end
  end

  always_comb begin
    for (int k = 0; k < DEPTH; k++) begin
      enables[k]                 = mem[k][ENABLE_BIT];
      setups[k*SETUP_W +: SETUP_W] = mem[k][SETUP_LO +: SETUP_W];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  resetValue_a: assert property (@(posedge clk) $past(!rst_n) |->
    mem[0] == CHAN0_RESET && mem[DEPTH-1] == CHANX_RESET)
    else $error("channel registers not at reset value");

  writeMerge_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && wrEn |=> mem[$past(wrAddr)] ==
      ((($past(mem[wrAddr]) & ~$past(wrMask)) | ($past(wrData) & $past(wrMask))) & ~RSVD_MASK))
    else $error("channel write not stored with reserved bits cleared");

endmodule
`default_nettype wire

// >>> hdl/ccr_channel_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_channel_config_regs
  import ccr_pkg::*;
#(
  // identification value is arbitrary
  parameter logic [ccr_pkg::REG_W-1:0] IDENT_CODE = 16'h5a50
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         ce,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ccr_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [ccr_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [ccr_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  // converter handshake
  input  wire logic                         convDone,
  // active channel routing
  output logic                              seqValid,
  output logic      [ccr_pkg::CHAN_W-1:0]   activeChannel,
  output logic      [ccr_pkg::SETUP_W-1:0]  activeSetup,
  output logic      [ccr_pkg::SEL_W-1:0]    posSelect,
  output logic      [ccr_pkg::SEL_W-1:0]    negSelect,
  output var ccr_pkg::ccr_src_t             posKind,
  output var ccr_pkg::ccr_src_t             negKind,
  // setups in use by enabled channels
  output logic      [ccr_pkg::SETUP_N-1:0]  setupsInUse
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [IDX_W-1:0]  regIdx;
  logic              aligned;
  logic              hitIdentity;
  logic              hitStatus;
  logic              hitChan;
  logic              mapped;
  logic              accessDone;

  assign regIdx      = paddr[ADDR_W-1:2];
  assign aligned     = (paddr[1:0] == 2'b00);
  assign hitIdentity = aligned && (regIdx == IDX_IDENTITY);
  assign hitStatus   = aligned && (regIdx == IDX_SEQ_STAT);
  assign hitChan     = aligned && (regIdx >= IDX_CHAN_BASE) && (regIdx <= IDX_CHAN_LAST);
  assign mapped      = hitIdentity || hitStatus || hitChan;
  assign accessDone  = psel && penable && pready;

  // ---------------------------------------------------------------
  // channel storage
  // ---------------------------------------------------------------
  logic                   chanWrEn;
  logic [REG_W-1:0]       chanWrMask;
  logic [REG_W-1:0]       busRdData;
  logic [CHAN_W-1:0]      seqRdAddr;
  logic [REG_W-1:0]       seqRdData;
  logic [CHAN_N-1:0]      chanEnables;
  logic [CHAN_N*SETUP_W-1:0] chanSetups;

  // status and identity writes are dropped without error
  assign chanWrEn   = accessDone && pwrite && hitChan;
  assign chanWrMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  ccr_chan_mem #(
    .DEPTH (CHAN_N),
    .WIDTH (REG_W)
  ) u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .wrEn    (chanWrEn),
    .wrAddr  (regIdx[CHAN_W-1:0]),
    .wrData  (pwdata[REG_W-1:0]),
    .wrMask  (chanWrMask),
    .rdAddrA (regIdx[CHAN_W-1:0]),
    .rdDataA (busRdData),
    .rdAddrB (seqRdAddr),
    .rdDataB (seqRdData),
    .enables (chanEnables),
    .setups  (chanSetups)
  );

  // ---------------------------------------------------------------
  // channel sequencer
  // ---------------------------------------------------------------
  ccr_seq u_seq (
    .clk           (clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .enables       (chanEnables),
    .convDone      (convDone),
    .rdAddr        (seqRdAddr),
    .rdData        (seqRdData),
    .seqValid      (seqValid),
    .activeChannel (activeChannel),
    .activeSetup   (activeSetup),
    .posSelect     (posSelect),
    .negSelect     (negSelect),
    .posKind       (posKind),
    .negKind       (negKind)
  );

  // ---------------------------------------------------------------
  // setup usage
  // ---------------------------------------------------------------
  logic [SETUP_N-1:0] next_setupsInUse;

  always_comb begin
    next_setupsInUse = '0;
    for (int k = 0; k < CHAN_N; k++) begin
      if (chanEnables[k]) begin
        next_setupsInUse[chanSetups[k*SETUP_W +: SETUP_W]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      setupsInUse <= '0;
    end else if (ce) begin
      setupsInUse <= next_setupsInUse;
    end
  end

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] next_prdata;
  logic [REG_W-1:0]  statusWord;

  assign statusWord = {setupsInUse, 3'h0, seqValid, activeChannel};

  always_comb begin
    next_prdata = '0;
    if (hitIdentity) begin
      next_prdata[REG_W-1:0] = IDENT_CODE;
    end else if (hitStatus) begin
      next_prdata[REG_W-1:0] = statusWord;
    end else if (hitChan) begin
      next_prdata[REG_W-1:0] = busRdData & ~RSVD_MASK;
    end
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= psel && penable && !pready;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? '0 : next_prdata;
        pslverr <= !mapped;
      end else begin
        prdata  <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  identityRead_a: assert property (@(posedge clk) disable iff (!rst_n)
    accessDone && !pwrite && hitIdentity |-> prdata == {16'h0000, IDENT_CODE})
    else $error("identity read returned wrong code");

  reservedRead_a: assert property (@(posedge clk) disable iff (!rst_n)
    accessDone && !pwrite && hitChan |-> prdata[11:10] == 2'b00 && prdata[31:16] == '0)
    else $error("reserved channel bits read nonzero");

  chanZeroReset_a: assert property (@(posedge clk)
    !rst_n ##1 rst_n && ce && psel && !penable && !pwrite && regIdx == IDX_CHAN_BASE
      && aligned |=> ##1 prdata == {16'h0000, CHAN0_RESET})
    else $error("channel zero not at reset value");

  waitState_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");

  unmappedErr_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    psel && penable && !pready && !mapped |=> pready && pslverr)
    else $error("unmapped access not flagged");

  setupUse_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    chanEnables[0] |=> setupsInUse[$past(chanSetups[SETUP_W-1:0])])
    else $error("enabled setup missing from usage mask");

endmodule
`default_nettype wire

// >>> hdl/ccr_pkg.sv
package ccr_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int REG_W   = 16;
  localparam int CHAN_N  = 16;
  localparam int CHAN_W  = 4;
  localparam int SEL_W   = 5;
  localparam int SETUP_W = 3;
  localparam int SETUP_N = 8;
  localparam int IDX_W   = 6;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_IDENTITY  = 6'h07;
  localparam logic [IDX_W-1:0] IDX_SEQ_STAT  = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_CHAN_BASE = 6'h10;
  localparam logic [IDX_W-1:0] IDX_CHAN_LAST = 6'h1f;

  // ---------------------------------------------------------------
  // reset values and field layout of a channel register
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] CHAN0_RESET = 16'h8001;
  localparam logic [REG_W-1:0] CHANX_RESET = 16'h0001;
  localparam logic [REG_W-1:0] RSVD_MASK   = 16'h0c00;
  localparam int ENABLE_BIT = 15;
  localparam int SETUP_LO   = 12;
  localparam int POS_LO     = 5;
  localparam int NEG_LO     = 0;

  // sequencer status register fields
  localparam int STAT_CHAN_LO = 0;
  localparam int STAT_RUN_BIT = 4;
  localparam int STAT_MASK_LO = 8;

  // ---------------------------------------------------------------
  // input select codes
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_AIN_LAST = 5'h10;
  localparam logic [SEL_W-1:0] SEL_TEMP_POS = 5'h11;
  localparam logic [SEL_W-1:0] SEL_TEMP_NEG = 5'h12;
  localparam logic [SEL_W-1:0] SEL_REF_POS  = 5'h15;
  localparam logic [SEL_W-1:0] SEL_REF_NEG  = 5'h16;

  typedef enum logic [2:0] {
    CCR_SRC_AIN      = 3'b000,
    CCR_SRC_TEMP_POS = 3'b001,
    CCR_SRC_TEMP_NEG = 3'b010,
    CCR_SRC_REF_POS  = 3'b011,
    CCR_SRC_REF_NEG  = 3'b100,
    CCR_SRC_NONE     = 3'b101
  } ccr_src_t;

  typedef enum logic [1:0] {
    CCR_SEQ_IDLE    = 2'b00,
    CCR_SEQ_FETCH   = 2'b01,
    CCR_SEQ_CAPTURE = 2'b10,
    CCR_SEQ_RUN     = 2'b11
  } ccr_seq_state_t;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // classify an input select code
  function automatic ccr_src_t srcKind(input logic [SEL_W-1:0] code);
    ccr_src_t k;
    k = CCR_SRC_NONE;
    if (code <= SEL_AIN_LAST) begin
      k = CCR_SRC_AIN;
    end else begin
      case (code)
        SEL_TEMP_POS: k = CCR_SRC_TEMP_POS;
        SEL_TEMP_NEG: k = CCR_SRC_TEMP_NEG;
        SEL_REF_POS:  k = CCR_SRC_REF_POS;
        SEL_REF_NEG:  k = CCR_SRC_REF_NEG;
        default:      k = CCR_SRC_NONE;
      endcase
    end
    return k;
  endfunction

  // next enabled channel above cur, wrapping; bit 4 says one was found
  function automatic logic [CHAN_W:0] nextEnabled(input logic [CHAN_N-1:0] en,
                                                  input logic [CHAN_W-1:0] cur);
    logic [CHAN_W:0]   res;
    logic [CHAN_W-1:0] cand;
    res = '0;
    for (int i = CHAN_N; i >= 1; i--) begin
      cand = cur + CHAN_W'(i);
      if (en[cand]) begin
        res = {1'b1, cand};
      end
    end
    return res;
  endfunction

endpackage

// >>> hdl/ccr_seq.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_seq
  import ccr_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  // channel state
  input  wire logic [ccr_pkg::CHAN_N-1:0] enables,
  input  wire logic                       convDone,
  output logic      [ccr_pkg::CHAN_W-1:0] rdAddr,
  input  wire logic [ccr_pkg::REG_W-1:0]  rdData,
  // active channel
  output logic                            seqValid,
  output logic      [ccr_pkg::CHAN_W-1:0] activeChannel,
  output logic      [ccr_pkg::SETUP_W-1:0] activeSetup,
  output logic      [ccr_pkg::SEL_W-1:0]  posSelect,
  output logic      [ccr_pkg::SEL_W-1:0]  negSelect,
  output var ccr_pkg::ccr_src_t           posKind,
  output var ccr_pkg::ccr_src_t           negKind
);

  ccr_seq_state_t  state;
  logic [CHAN_W:0] nextChan;
  logic            anyEnabled;

  assign anyEnabled = |enables;
  assign nextChan   = nextEnabled(enables, rdAddr);

  // ---------------------------------------------------------------
  // channel stepping
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state  <= CCR_SEQ_IDLE;
      rdAddr <= '0;
    end else if (ce) begin
      case (state)
        CCR_SEQ_IDLE: begin
          if (anyEnabled) begin
            rdAddr <= nextChan[CHAN_W-1:0];
            state  <= CCR_SEQ_FETCH;
          end
        end
        CCR_SEQ_FETCH:   state <= CCR_SEQ_CAPTURE;
        CCR_SEQ_CAPTURE: state <= CCR_SEQ_RUN;
        CCR_SEQ_RUN: begin
          if (!anyEnabled) begin
            state <= CCR_SEQ_IDLE;
          end else if (convDone) begin
            rdAddr <= nextChan[CHAN_W-1:0];
            state  <= CCR_SEQ_FETCH;
          end
        end
        default: state <= CCR_SEQ_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // routing outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seqValid      <= 1'b0;
      activeChannel <= '0;
      activeSetup   <= '0;
      posSelect     <= '0;
      negSelect     <= '0;
      posKind       <= CCR_SRC_NONE;
      negKind       <= CCR_SRC_NONE;
    end else if (ce) begin
      if (state == CCR_SEQ_CAPTURE) begin
        seqValid      <= 1'b1;
        activeChannel <= rdAddr;
        activeSetup   <= rdData[SETUP_LO +: SETUP_W];
        posSelect     <= rdData[POS_LO +: SEL_W];
        negSelect     <= rdData[NEG_LO +: SEL_W];
        posKind       <= srcKind(rdData[POS_LO +: SEL_W]);
        negKind       <= srcKind(rdData[NEG_LO +: SEL_W]);
      end else if (state != CCR_SEQ_RUN || !anyEnabled || convDone) begin
        seqValid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  autoStep_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    state == CCR_SEQ_RUN && convDone && anyEnabled |-> ##3 seqValid)
    else $error("sequencer did not step to the next channel");

  ascendOrder_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    state == CCR_SEQ_RUN && convDone && anyEnabled
      |=> rdAddr == $past(nextChan[CHAN_W-1:0]))
    else $error("sequencer did not take the next channel upward");

  enabledOnly_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(seqValid) |-> $past(enables[rdAddr], 2))
    else $error("disabled channel made active");

  setupRoute_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(seqValid) |-> activeSetup == $past(rdData[SETUP_LO +: SETUP_W]))
    else $error("setup select not applied");

  inputRoute_a: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(seqValid) |-> posSelect == $past(rdData[POS_LO +: SEL_W])
                     && negSelect == $past(rdData[NEG_LO +: SEL_W]))
    else $error("input select not applied");

  srcDecode_a: assert property (@(posedge clk) disable iff (!rst_n)
    seqValid |-> posKind == srcKind(posSelect) && negKind == srcKind(negSelect))
    else $error("input kind does not match select code");

endmodule
`default_nettype wire

// >>> sim/ccr_channel_config_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_channel_config_regs_bench;
  import ccr_pkg::*;
  // value is arbitrary
  localparam logic [15:0] IDENT_CODE = 16'h6b70;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  pstrb = 4'hf;
  logic        go = 1'b0, pready, pslverr, seqValid, convDone;
  logic [7:0]  paddr = 8'h00, holdCycles = 8'h03, setupsInUse;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  activeChannel;
  logic [2:0]  activeSetup;
  logic [4:0]  posSelect, negSelect;
  ccr_src_t    posKind, negKind;
  int          miscompares = 0, checksDone = 0;

  always #2.5 clk = ~clk;

  ccr_channel_config_regs #(.IDENT_CODE(IDENT_CODE)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convDone(convDone), .seqValid(seqValid), .activeChannel(activeChannel),
    .activeSetup(activeSetup), .posSelect(posSelect), .negSelect(negSelect),
    .posKind(posKind), .negKind(negKind), .setupsInUse(setupsInUse));

  ccr_conv_model conv (.clk(clk), .rst_n(rst_n), .go(go), .holdCycles(holdCycles),
    .seqValid(seqValid), .convDone(convDone));

  // -------------------------------------------------
  // shared tasks
  // -------------------------------------------------
  task automatic give_verdict;
    if (miscompares == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk) penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {16'h0, d}, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, eerr});
  endtask

  task automatic route_chk(input logic [3:0] ch, input logic [2:0] su,
                           input logic [4:0] ps, input logic [4:0] ng,
                           input ccr_src_t pk, input ccr_src_t nk);
    check(32'(activeChannel), 32'(ch));
    check(32'(activeSetup), 32'(su));
    check({22'h0, posSelect, negSelect}, {22'h0, ps, ng});
    check({26'h0, posKind, negKind}, {26'h0, pk, nk});
  endtask

  task automatic next_chan(input logic [3:0] ch, input logic [2:0] su,
                           input logic [4:0] ps, input logic [4:0] ng,
                           input ccr_src_t pk, input ccr_src_t nk);
    int n;
    n = 0;
    while (seqValid !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (seqValid !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      give_verdict();
    end
    route_chk(ch, su, ps, ng, pk, nk);
  endtask

  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic scen_reset;
    logic [31:0] r;
    logic        e;
    rdchk(8'h40, 32'h8001, 1'b0);
    apb(1'b0, 8'h1c, 32'h0, r, e);
    check(r, {16'h0, IDENT_CODE});
    check(32'(r[15:4]), 32'(IDENT_CODE[15:4]));
    for (int c = 1; c < 16; c++) begin
      rdchk(8'(8'h40 + 4 * c), 32'h0001, 1'b0);
    end
    check(32'(setupsInUse), 32'h01);
    check({31'h0, seqValid}, 32'h1);
    route_chk(4'h0, 3'h0, 5'h00, 5'h01, CCR_SRC_AIN, CCR_SRC_AIN);
  endtask

  task automatic scen_refuse;
    wr(8'h1c, 16'hffff);
    rdchk(8'h1c, {16'h0, IDENT_CODE}, 1'b0);
    rdchk(8'h00, 32'h0, 1'b1);
    rdchk(8'h41, 32'h0, 1'b1);
  endtask

  task automatic scen_strobe;
    pstrb <= 4'h1;
    wr(8'h44, 16'hffff);
    pstrb <= 4'hf;
    rdchk(8'h44, 32'h00ff, 1'b0);
  endtask

  task automatic scen_sequence;
    logic [4:0] sv;
    wr(8'h48, 16'hb232);
    wr(8'h54, 16'hfeb6);
    rdchk(8'h54, 32'hf2b6, 1'b0);
    go <= 1'b1;
    next_chan(4'h2, 3'h3, 5'h11, 5'h12, CCR_SRC_TEMP_POS, CCR_SRC_TEMP_NEG);
    next_chan(4'h5, 3'h7, 5'h15, 5'h16, CCR_SRC_REF_POS, CCR_SRC_REF_NEG);
    check(32'(setupsInUse), 32'h89);
    holdCycles <= 8'd20;
    next_chan(4'h0, 3'h0, 5'h00, 5'h01, CCR_SRC_AIN, CCR_SRC_AIN);
    wr(8'h40, 16'h0001);
    next_chan(4'h2, 3'h3, 5'h11, 5'h12, CCR_SRC_TEMP_POS, CCR_SRC_TEMP_NEG);
    next_chan(4'h5, 3'h7, 5'h15, 5'h16, CCR_SRC_REF_POS, CCR_SRC_REF_NEG);
    next_chan(4'h2, 3'h3, 5'h11, 5'h12, CCR_SRC_TEMP_POS, CCR_SRC_TEMP_NEG);
    check(32'(setupsInUse), 32'h88);
    // clock enable low freezes the active channel
    ce <= 1'b0;
    sv = {seqValid, activeChannel};
    repeat (8) @(posedge clk);
    check({27'h0, seqValid, activeChannel}, {27'h0, sv});
    ce <= 1'b1;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    scen_reset();
    scen_refuse();
    scen_strobe();
    scen_sequence();
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> sim/ccr_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_conv_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // pacing
  input  wire logic       go,
  input  wire logic [7:0] holdCycles,
  // handshake
  input  wire logic       seqValid,
  output logic            convDone
);
  logic [7:0] cnt;

  // -------------------------------------------------
  // one pulse per conversion, holdCycles+1 cycles after start
  // -------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt      <= 8'h00;
      convDone <= 1'b0;
    end else begin
      convDone <= 1'b0;
      if (!seqValid || convDone) begin
        cnt <= 8'h00;
      end else if (go) begin
        cnt <= cnt + 8'h01;
        if (cnt == holdCycles) begin
          convDone <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire
